// [rtl/vcs_pkg.sv]
// shared constants and types for the current-sample filter device
package vcs_pkg;
  // filter structure
  localparam int NCH = 4;
  localparam int CH_USED = 3;
  localparam int FILTER_OVERSAMPLING_RATIO = 128;
  localparam int INTEGRATOR_OVERSAMPLING_RATIO = 8;
  localparam int EFFECTIVE_OVERSAMPLING_RATIO = FILTER_OVERSAMPLING_RATIO * INTEGRATOR_OVERSAMPLING_RATIO;
  localparam int SINC_W = 22;
  localparam int SAMP_W = 32;
  // serial read-out: three 32-bit samples per frame
  localparam int LINK_BITS = CH_USED * SAMP_W;
  localparam logic [6:0] LINK_LAST = 7'h5f;
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [3:0] OFF_DATA_HI = 4'h1;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_SRST_BIT = 8;
  localparam logic [3:0] CTRL_EN_RST = 4'h0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_LINK_LSB = 4;
  localparam int STAT_CNT_LSB = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } vcs_bus_t;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic mosi;
  } vcs_spi_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_SHIFT = 2'b01,
    LS_DONE = 2'b10
  } vcs_link_t;
endpackage

// [rtl/vcs_filter_chan.sv]
// one sinc3 filter channel with its integrator stage
`timescale 1ns/1ns
module vcs_filter_chan #(
  parameter int FILTER_OVERSAMPLING_RATIO = vcs_pkg::FILTER_OVERSAMPLING_RATIO,
  parameter int INTEGRATOR_OVERSAMPLING_RATIO = vcs_pkg::INTEGRATOR_OVERSAMPLING_RATIO,
  parameter int W = vcs_pkg::SINC_W,
  parameter int OW = vcs_pkg::SAMP_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic enable,
  // modulator bit, qualified by tick
  input wire logic tick,
  input wire logic bitIn,
  // effective sample out
  output logic [OW-1:0] sample,
  output logic valid
);
  localparam int DW = $clog2(FILTER_OVERSAMPLING_RATIO);
  localparam int IW = $clog2(INTEGRATOR_OVERSAMPLING_RATIO);
  localparam logic [DW-1:0] LAST_D = DW'(FILTER_OVERSAMPLING_RATIO - 1);
  localparam logic [IW-1:0] LAST_I = IW'(INTEGRATOR_OVERSAMPLING_RATIO - 1);

  typedef struct packed {
    logic [W-1:0] i1;
    logic [W-1:0] i2;
    logic [W-1:0] i3;
    logic [W-1:0] c1;
    logic [W-1:0] c2;
    logic [W-1:0] c3;
    logic [DW-1:0] decCnt;
    logic [IW-1:0] intCnt;
    logic [OW-1:0] acc;
    logic [OW-1:0] sample;
    logic valid;
  } vcs_chan_t;

  vcs_chan_t q;
  vcs_chan_t d;

  always_comb begin
    logic [W-1:0] d1;
    logic [W-1:0] d2;
    logic [W-1:0] d3;
    d1 = '0;
    d2 = '0;
    d3 = '0;
    d = q;
    d.valid = 1'b0;
    if (tick) begin
      // unsigned 0/1 input; wrap-around keeps the comb result exact
      d.i1 = q.i1 + W'(bitIn); // RULE19
      d.i2 = q.i2 + q.i1;
      d.i3 = q.i3 + q.i2;
      d.decCnt = q.decCnt + 1'b1;
      if (q.decCnt == LAST_D) begin
        d.decCnt = '0;
        d1 = q.i3 - q.c1; // RULE19
        d2 = d1 - q.c2;
        d3 = d2 - q.c3;
        d.c1 = q.i3;
        d.c2 = d1;
        d.c3 = d2;
        d.intCnt = q.intCnt + 1'b1;
        d.acc = q.acc + OW'(d3); // RULE20
        if (q.intCnt == LAST_I) begin
          d.intCnt = '0;
          d.sample = q.acc + OW'(d3); // RULE20
          d.acc = '0;
          d.valid = 1'b1;
        end
      end
    end
    if (clear || !enable) begin
      d = '0; // RULE16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sample = q.sample;
  assign valid = q.valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dec_step;
    tick && enable && !clear && q.decCnt == LAST_D
      |=> q.intCnt == IW'($past(q.intCnt) + 1'b1);
  endproperty
  a_dec_step: assert property (p_dec_step) // RULE19
    else $error("filter output not taken after full decimation");

  property p_int_sum;
    valid |-> $past(q.intCnt) == LAST_I && q.acc == '0;
  endproperty
  a_int_sum: assert property (p_int_sum) // RULE20
    else $error("effective sample not after integrator count");

  c_valid: cover property (valid);
endmodule // vcs_filter_chan

// [rtl/vcs_filter_device.sv]
// current-sample filter device: filters, sample-ready flag, serial read-out
// How it works
// RULE1 - soft reset returns block to defaults; here the filter enables keep their value
// RULE2 - host trigger timer counts modulator clock
// RULE3 - host trigger falls after full count
// RULE4 - host trigger rise fixed-spaced, before fall
// RULE5 - host makes trigger edges in hardware
// RULE6 - host voltage scan shorter than period
// RULE7 - host keeps trigger timer stopped initially
// RULE8 - host converter scans all voltage channels
// RULE9 - host converter clock 3 MHz, 4+16 cycles; here half the modulator clock, 7.8125 MHz
// RULE10 - host converter interrupts after full scan
// RULE11 - host presents voltages as 16-bit signed
// RULE12 - host channels two, one, zero: A, B, C
// RULE13 - host resets device, runs 3-wire 3 MHz link; here the bench clocks it at 15.625 MHz
// RULE14 - host interrupts on sample-ready rising edge; here the bench polls the ready level each clock
// RULE15 - host withholds modulator clock until start
// RULE16 - filters 1-3 used, filter 4 idle
// RULE17 - each filter keeps 32-bit sample register
// RULE18 - enabled filters forward modulator clock out
// RULE19 - sinc3 filter, decimation 128, into integrator
// RULE20 - integrator sums 8, effective ratio 1024
// RULE21 - ready high from new sample until read
// RULE22 - host start order keeps timing repeatable
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module vcs_filter_device #(
  parameter int NCH = vcs_pkg::NCH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire vcs_pkg::vcs_bus_t bus,
  output logic [31:0] rdata,
  // modulator side
  input wire logic modClkIn,
  input wire logic [NCH-1:0] bitIn,
  output logic [NCH-1:0] clkOut,
  // host serial link
  input wire vcs_pkg::vcs_spi_t spiIn,
  output logic miso,
  output logic sampleReady
);
  typedef struct packed {
    logic modS1;
    logic modS2;
    logic modS3;
    logic [NCH-1:0] bitS1;
    logic [NCH-1:0] bitS2;
    vcs_pkg::vcs_spi_t spiS1;
    vcs_pkg::vcs_spi_t spiS2;
    vcs_pkg::vcs_spi_t spiS3;
    logic [NCH-1:0] ctrlEn;
    logic srst;
    logic [NCH-1:0][vcs_pkg::SAMP_W-1:0] data;
    logic [vcs_pkg::LINK_BITS-1:0] shift;
    logic [6:0] bitCnt;
    vcs_pkg::vcs_link_t link;
    logic ready;
    logic miso;
    logic [NCH-1:0] clkOut;
    logic [31:0] rdata;
  } vcs_state_t;

  vcs_state_t q;
  vcs_state_t d;
  logic tick;
  logic readDone;
  logic newSample;
  logic [NCH-1:0] chValid;
  logic [NCH-1:0][vcs_pkg::SAMP_W-1:0] chSample;

  assign tick = q.modS2 & ~q.modS3;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      vcs_filter_chan u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .clear(q.srst),
        .enable(q.ctrlEn[gi]),
        .tick(tick),
        .bitIn(q.bitS2[gi]),
        .sample(chSample[gi]),
        .valid(chValid[gi])
      );
    end
  endgenerate

  // all channels share one tick, so any enabled valid marks a new set
  assign newSample = |(chValid & q.ctrlEn);
  // host samples on sclk rise; done once the last of 96 bits is taken
  assign readDone = q.link == vcs_pkg::LS_SHIFT && q.spiS2.sclk
    && !q.spiS3.sclk && q.bitCnt == vcs_pkg::LINK_LAST;

  always_comb begin
    d = q;
    d.modS1 = modClkIn;
    d.modS2 = q.modS1;
    d.modS3 = q.modS2;
    d.bitS1 = bitIn;
    d.bitS2 = q.bitS1;
    d.spiS1 = spiIn;
    d.spiS2 = q.spiS1;
    d.spiS3 = q.spiS2;
    d.srst = 1'b0;
    d.rdata = '0;
    d.clkOut = {NCH{q.modS2}} & q.ctrlEn; // RULE18
    for (int i = 0; i < NCH; i++) begin
      if (chValid[i]) begin
        d.data[i] = chSample[i]; // RULE17
      end
    end
    // serial read-out; a snapshot at select keeps a frame consistent
    if (q.spiS3.csN && !q.spiS2.csN) begin
      d.shift = {q.data[0], q.data[1], q.data[2]};
      d.miso = q.data[0][vcs_pkg::SAMP_W-1];
      d.bitCnt = '0;
      d.link = vcs_pkg::LS_SHIFT;
    end else if (q.spiS2.csN) begin
      d.link = vcs_pkg::LS_IDLE;
      d.miso = 1'b0;
    end else if (q.link == vcs_pkg::LS_SHIFT) begin
      if (q.spiS2.sclk && !q.spiS3.sclk) begin
        d.bitCnt = q.bitCnt + 1'b1;
        if (readDone) begin
          d.link = vcs_pkg::LS_DONE;
        end
      end else if (!q.spiS2.sclk && q.spiS3.sclk) begin
        d.shift = {q.shift[vcs_pkg::LINK_BITS-2:0], 1'b0};
        d.miso = q.shift[vcs_pkg::LINK_BITS-2];
      end
    end
    // set wins over clear
    if (readDone) begin
      d.ready = 1'b0; // RULE21
    end
    if (newSample) begin
      d.ready = 1'b1; // RULE21
    end
    if (bus.wr) begin
      if (bus.addr == vcs_pkg::OFF_CTRL) begin
        d.ctrlEn = bus.wdata[vcs_pkg::CTRL_EN_LSB +: NCH];
        d.srst = bus.wdata[vcs_pkg::CTRL_SRST_BIT];
      end
    end
    if (bus.rd) begin
      if (bus.addr == vcs_pkg::OFF_CTRL) begin
        d.rdata[vcs_pkg::CTRL_EN_LSB +: NCH] = q.ctrlEn;
      end else if (bus.addr == vcs_pkg::OFF_STAT) begin
        d.rdata[vcs_pkg::STAT_READY_BIT] = q.ready;
        d.rdata[vcs_pkg::STAT_LINK_LSB +: 2] = q.link;
        d.rdata[vcs_pkg::STAT_CNT_LSB +: 7] = q.bitCnt;
      end else if (bus.addr[7:4] == vcs_pkg::OFF_DATA_HI
          && bus.addr[1:0] == 2'b00) begin
        d.rdata = q.data[bus.addr[3:2]];
      end
    end
    // soft reset clears samples, flag and link, keeps enables
    if (q.srst) begin
      d.data = '0; // RULE1
      d.ready = 1'b0;
      d.link = vcs_pkg::LS_IDLE;
      d.bitCnt = '0;
      d.miso = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrlEn <= vcs_pkg::CTRL_EN_RST;
      q.link <= vcs_pkg::LS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign clkOut = q.clkOut;
  assign miso = q.miso;
  assign sampleReady = q.ready;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_srst;
    q.srst |=> !sampleReady && q.data == '0 && q.link == vcs_pkg::LS_IDLE;
  endproperty
  a_srst: assert property (p_srst) // RULE1
    else $error("soft reset left state behind");

  property p_unused;
    !q.ctrlEn[3] [*2] |-> !chValid[3];
  endproperty
  a_unused: assert property (p_unused) // RULE16
    else $error("disabled filter produced a sample");

  property p_latch;
    chValid[0] && !q.srst |=> q.data[0] == $past(chSample[0]);
  endproperty
  a_latch: assert property (p_latch) // RULE17
    else $error("sample register not loaded");

  property p_clk_fwd;
    q.ctrlEn[0] && q.modS2 ##1 q.ctrlEn[0] |-> clkOut[0];
  endproperty
  a_clk_fwd: assert property (p_clk_fwd) // RULE18
    else $error("modulator clock not forwarded");

  property p_clk_off;
    q.ctrlEn == '0 |=> clkOut == '0;
  endproperty
  a_clk_off: assert property (p_clk_off) // RULE18
    else $error("clock output while disabled");

  property p_ready_set;
    newSample && !q.srst |=> sampleReady;
  endproperty
  a_ready_set: assert property (p_ready_set) // RULE21
    else $error("ready not raised on new sample");

  property p_ready_hold;
    sampleReady && !readDone && !q.srst |=> sampleReady;
  endproperty
  a_ready_hold: assert property (p_ready_hold) // RULE21
    else $error("ready dropped before read-out finished");

  property p_ready_clr;
    readDone && !newSample |=> !sampleReady;
  endproperty
  a_ready_clr: assert property (p_ready_clr) // RULE21
    else $error("ready stayed high after full read");

  c_ready: cover property (!sampleReady ##1 sampleReady);
  c_read: cover property (readDone);
  c_srst: cover property (q.srst ##1 !sampleReady);
endmodule // vcs_filter_device

// [sim/vcs_host_model.sv]
// host-side model: modulator clock, bitstreams, three-wire read-out
`timescale 1ns/1ns
module vcs_host_model #(
  parameter int MOD_HALF = 32,
  parameter int EFFECTIVE_OVERSAMPLING_RATIO = vcs_pkg::EFFECTIVE_OVERSAMPLING_RATIO,
  // trigger rise point inside the period; any fixed value below the end
  parameter int TRIG_RISE = 512,
  // converter clock is half the modulator clock; cycles per channel
  parameter int ADC_DIV = 2,
  parameter int SH_CYC = 4,
  parameter int CONV_CYC = 16,
  parameter int N_VCH = 3
) (
  // bitstream pattern from the bench
  input wire logic [3:0] pattern,
  // lines toward the device
  output logic modClk,
  output logic [3:0] bits,
  output vcs_pkg::vcs_spi_t spi,
  // line from the device
  input wire logic miso
);
  logic run = 1'b0;
  // trigger timer and voltage scan, counted in modulator clocks
  logic trigRun = 1'b0;
  logic trigOut = 1'b0;
  logic scanIrq = 1'b0;
  int trigCnt = 0;
  int edgeNo = 0;
  int lastRise = 0;
  int trigGap = 0;
  int trigFalls = 0;
  int scanLeft = 0;
  int scansDone = 0;
  // index is the analog channel: two is phase A, one B, zero C
  localparam logic [13:0] RAW [3] = '{14'h0a00, 14'h2000, 14'h3600};
  logic [15:0] volt [3] = '{default: 16'h0};

  assign bits = pattern;

  // timer shares the modulator clock, so both paths keep one time base
  always @(posedge modClk) begin
    edgeNo <= edgeNo + 1;
    scanIrq <= 1'b0;
    if (scanLeft > 0) begin
      scanLeft <= scanLeft - 1;
      if (scanLeft == 1) begin
        scansDone <= scansDone + 1;
        scanIrq <= 1'b1;
        for (int k = 0; k < 3; k++) begin
          volt[k] <= {~RAW[k][13], RAW[k][12:0], 2'b00};
        end
      end
    end
    if (trigRun) begin
      if (trigCnt == EFFECTIVE_OVERSAMPLING_RATIO - 1) begin
        trigCnt <= 0;
        trigOut <= 1'b0;
        trigFalls <= trigFalls + 1;
      end else begin
        trigCnt <= trigCnt + 1;
        if (trigCnt == TRIG_RISE) begin
          // both edges come from the count, so rise spacing is fixed
          trigOut <= 1'b1;
          trigGap <= edgeNo - lastRise;
          lastRise <= edgeNo;
          // whole scan must end well before the next rise
          scanLeft <= N_VCH * (SH_CYC + CONV_CYC) * ADC_DIV;
        end
      end
    end
  end

  initial begin
    modClk = 1'b0;
    spi = '{csN: 1'b1, sclk: 1'b0, mosi: 1'b0};
  end

  // clock withheld until start so no sample begins half-configured
  always begin
    #MOD_HALF;
    modClk = run & ~modClk;
  end

  // start step: clock goes out only when the host says so
  task automatic startClock();
    trigRun = 1'b1;
    run = 1'b1;
  endtask

  // manual chip select; serial clock idles low outside frames
  task automatic readFrame(input int half, output logic [95:0] got);
    // step off the device clock edge before touching the lines
    #1;
    spi.csN = 1'b0;
    for (int i = 95; i >= 0; i--) begin
      #half;
      got[i] = miso;
      spi.sclk = 1'b1;
      #half;
      spi.sclk = 1'b0;
    end
    #half;
    spi.csN = 1'b1;
  endtask
endmodule // vcs_host_model

// [sim/tb_voltage_current_sample_sync.sv]
// testbench for the current-sample filter device
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
  end \
end

module tb_voltage_current_sample_sync;
  localparam logic [31:0] FULL = 32'(vcs_pkg::INTEGRATOR_OVERSAMPLING_RATIO * vcs_pkg::FILTER_OVERSAMPLING_RATIO ** 3);
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] exp;
    logic [31:0] mask;
  } vcs_row_t;
  // unmapped places read as zero; disabled channel stays zeroed
  vcs_row_t rows [8] = '{
    '{8'h00, 32'h7, 32'hffffffff}, '{8'h04, 32'h1, 32'h31},
    '{8'h10, FULL, 32'hffffffff}, '{8'h14, 32'h0, 32'hffffffff},
    '{8'h18, FULL, 32'hffffffff}, '{8'h1c, 32'h0, 32'hffffffff},
    '{8'h08, 32'h0, 32'hffffffff}, '{8'h20, 32'h0, 32'hffffffff}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  vcs_pkg::vcs_bus_t bus = '0;
  logic [3:0] pattern = 4'h0;
  logic [31:0] rdata;
  logic modClk;
  logic [3:0] bitIn;
  logic [3:0] clkOut;
  vcs_pkg::vcs_spi_t spi;
  logic miso;
  logic sampleReady;
  logic [31:0] got;
  logic [95:0] frame;
  logic [3:0] seen;
  int n_fail = 0;
  int compares = 0;

  always #2 clk = ~clk;

  vcs_filter_device i_vcs_filter_device (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .modClkIn(modClk), .bitIn(bitIn), .clkOut(clkOut),
    .spiIn(spi), .miso(miso), .sampleReady(sampleReady));

  vcs_host_model i_vcs_host_model (
    .pattern(pattern), .modClk(modClk), .bits(bitIn), .spi(spi),
    .miso(miso));

  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  // bounded wait for a new effective sample
  task automatic waitReady();
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      if (sampleReady === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] %0t ready timeout", $time);
    summarize();
  endtask

  initial begin
    repeat (6) @(posedge clk);
    `CHK({rdata, clkOut, miso, sampleReady}, 38'h0)
    rst_n <= 1'b1;
    @(posedge clk);
    regWr(vcs_pkg::OFF_CTRL, 32'h7);
    // channel four gets ones too, yet is disabled
    pattern <= 4'b1101;
    i_vcs_host_model.startClock();
    seen = 4'h0;
    repeat (64) begin
      @(posedge clk);
      seen = seen | clkOut;
    end
    `CHK(seen, 4'h7)
    waitReady();
    `CHK(i_vcs_host_model.trigFalls, 1)
    `CHK(i_vcs_host_model.scansDone, 1)
    // first sample holds pipeline fill, read only to release ready
    i_vcs_host_model.readFrame(32, frame);
    repeat (8) @(posedge clk);
    `CHK(sampleReady, 1'b0)
    waitReady();
    `CHK(i_vcs_host_model.trigFalls, 2)
    `CHK(i_vcs_host_model.trigGap, vcs_pkg::EFFECTIVE_OVERSAMPLING_RATIO)
    foreach (rows[k]) begin
      regRd(rows[k].addr, got);
      `CHK(got & rows[k].mask, rows[k].exp)
    end
    #1;
    `CHK(rdata, 32'h0)
    // settled samples must come out whole, filter 1 first
    i_vcs_host_model.readFrame(32, frame);
    `CHK(frame, {FULL, 32'h0, FULL})
    repeat (8) @(posedge clk);
    `CHK(sampleReady, 1'b0)
    regWr(vcs_pkg::OFF_CTRL, 32'h107);
    repeat (2) @(posedge clk);
    regRd(8'h10, got);
    `CHK(got, 32'h0)
    regRd(vcs_pkg::OFF_CTRL, got);
    `CHK(got, 32'h7)
    summarize();
  end
endmodule // tb_voltage_current_sample_sync
